// file: rtl/mbi_port.sv
// module: parallel microcontroller bus front end with latched address


`timescale 1ns/1ps

module mbi_port #(
    parameter int ADDR_W = mbi_pkg::ADDR_W,
    parameter int BYTE_W = mbi_pkg::BYTE_W
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire mbi_pkg::mbi_bus_mode_t bus_mode,
    input wire mbi_pkg::mbi_c0_mode_t c0_mode,
    input wire mbi_pkg::mbi_c1_mode_t c1_mode,
    input wire logic addr_strobe_alt,
    input wire logic [7:0] lower_addr_data_port_in,
    output logic [7:0] lower_addr_data_port_out,
    output logic lower_addr_data_port_oe,
    input wire logic [7:0] upper_addr_data_port_in,
    output logic [7:0] upper_addr_data_port_out,
    output logic upper_addr_data_port_oe,
    input wire logic ctrl_input_zero,
    input wire logic ctrl_input_one,
    input wire logic ctrl_input_two,
    input wire logic block_select,
    input wire logic [15:0] rd_data,
    output logic [15:0] array_addr,
    output logic [2:0] array_ctrl,
    output logic rd_active,
    output logic wr_active,
    output logic fetch_active
);

    ////////////////////////////////////////////////////////////////////
    // elaboration check: pins are fixed at two bytes of address
    // a wider bus would need wider pins, which the port list fixes
    if (BYTE_W != 8 || ADDR_W != 2 * BYTE_W)
    begin : g_bad_width
        $error("mbi_port: width parameters not supported");
    end

    ////////////////////////////////////////////////////////////////////
    // two-flop synchronisers on every pin input
    // bits are synced one by one; the strobe shares the same latency,
    // so a torn bus word is only taken while the strobe is still high
    logic [20:0] sync1_r;
    logic [20:0] sync2_r;
    logic [20:0] sync_nxt;

    always_comb
    begin
        sync_nxt = {addr_strobe_alt, ctrl_input_two, ctrl_input_one,
            ctrl_input_zero, upper_addr_data_port_in,
            lower_addr_data_port_in, block_select};
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_r <= 21'h00000;
            sync2_r <= 21'h00000;
        end
        else
        begin
            sync1_r <= sync_nxt;
            sync2_r <= sync1_r;
        end
    end

    logic s_as;
    logic [2:0] s_ctl;
    logic [7:0] s_lo;
    logic [7:0] s_hi;
    logic s_sel;

    assign s_as = sync2_r[20];
    assign s_ctl = sync2_r[19:17];
    assign s_hi = sync2_r[16:9];
    assign s_lo = sync2_r[8:1];
    assign s_sel = sync2_r[0];

    ////////////////////////////////////////////////////////////////////
    // control decode
    // decoded levels feed the arrays; the read level also feeds the drive logic
    logic rd_dec;
    logic wr_dec;

    // one address word from the two port bytes
    function automatic logic [15:0] f_join(
        input logic [7:0] hi,
        input logic [7:0] lo
    );
        return {hi, lo};
    endfunction : f_join

    // read level for the selected meaning of control one
    function automatic logic f_rd(
        input mbi_pkg::mbi_c0_mode_t m0,
        input mbi_pkg::mbi_c1_mode_t m1,
        input logic [2:0] ctl
    );
        logic dir_rd;
        logic rd;

        // direction pin only qualifies the phase in direction wiring
        dir_rd = (m0 == mbi_pkg::MBI_C0_RW) ? ctl[0] : 1'b1;
        case (m1)
            mbi_pkg::MBI_C1_RD_N: rd = !ctl[1];
            mbi_pkg::MBI_C1_PROGRAM_FETCH_N_N: rd = !ctl[1];
            mbi_pkg::MBI_C1_DS_N: rd = !ctl[1] && dir_rd;
            mbi_pkg::MBI_C1_ECLK: rd = ctl[1] && dir_rd;
            default: rd = 1'b0;
        endcase
        return rd;
    endfunction : f_rd

    // write level: strobe form, or direction during the bus phase
    function automatic logic f_wr(
        input mbi_pkg::mbi_c0_mode_t m0,
        input mbi_pkg::mbi_c1_mode_t m1,
        input logic [2:0] ctl
    );
        logic phase;
        logic wr;

        // only a data strobe marks its phase by a low level
        phase = (m1 == mbi_pkg::MBI_C1_DS_N) ? !ctl[1] : ctl[1];
        case (m0)
            mbi_pkg::MBI_C0_WR_N: wr = !ctl[0];
            mbi_pkg::MBI_C0_RW: wr = phase && !ctl[0];
            default: wr = 1'b0;
        endcase
        return wr;
    endfunction : f_wr

    always_comb
    begin
        rd_dec = f_rd(c0_mode, c1_mode, s_ctl);
        wr_dec = f_wr(c0_mode, c1_mode, s_ctl);
    end

    ////////////////////////////////////////////////////////////////////
    // address capture
    // held address outlives the strobe for the whole data phase
    mbi_pkg::mbi_state_t st_r;
    mbi_pkg::mbi_state_t st_nxt;
    logic [15:0] addr_r;
    logic [15:0] addr_nxt;

    always_comb
    begin
        st_nxt = st_r;
        addr_nxt = addr_r;
        case (st_r)
            mbi_pkg::MBI_ST_IDLE:
                if (s_as)
                begin
                    st_nxt = mbi_pkg::MBI_ST_HELD;
                    addr_nxt = f_join(s_hi, s_lo);
                end
            mbi_pkg::MBI_ST_HELD:
                // track while strobe high, hold after fall
                if (s_as)
                    addr_nxt = f_join(s_hi, s_lo);
                else
                    st_nxt = mbi_pkg::MBI_ST_IDLE;
            default: st_nxt = mbi_pkg::MBI_ST_IDLE;
        endcase

        // non-muxed: both ports carry the live address, no latch needed
        if (bus_mode == mbi_pkg::MBI_NONMUX)
            addr_nxt = f_join(s_hi, s_lo);
        else if (bus_mode == mbi_pkg::MBI_PAGE)
            addr_nxt[7:0] = s_lo;
        else if (bus_mode == mbi_pkg::MBI_MUX_LOW)
            addr_nxt[15:8] = s_hi;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= mbi_pkg::MBI_ST_IDLE;
            addr_r <= mbi_pkg::RST_ADDR;
        end
        else
        begin
            st_r <= st_nxt;
            addr_r <= addr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // data drive
    // out registers follow rd_data every edge; only oe gates the pins
    logic [7:0] lo_out_nxt;
    logic [7:0] hi_out_nxt;
    logic lo_oe_nxt;
    logic hi_oe_nxt;
    logic drive;

    always_comb
    begin
        // no drive while the strobe still marks an address phase
        drive = rd_dec && s_sel && !s_as;
        lo_out_nxt = rd_data[7:0];
        hi_out_nxt = rd_data[15:8];
        lo_oe_nxt = 1'b0;
        hi_oe_nxt = 1'b0;

        case (bus_mode)
            mbi_pkg::MBI_MUX_LOW: lo_oe_nxt = drive;
            mbi_pkg::MBI_NONMUX: lo_oe_nxt = 1'b0;
            mbi_pkg::MBI_PAGE:
            begin
                // upper lines carry the data byte
                hi_out_nxt = rd_data[7:0];
                hi_oe_nxt = drive;
            end
            mbi_pkg::MBI_BURST:
            begin
                lo_oe_nxt = drive;
                hi_oe_nxt = drive;
            end
            default: lo_oe_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lower_addr_data_port_out <= mbi_pkg::RST_BYTE;
            upper_addr_data_port_out <= mbi_pkg::RST_BYTE;
            lower_addr_data_port_oe <= 1'b0;
            upper_addr_data_port_oe <= 1'b0;
        end
        else
        begin
            lower_addr_data_port_out <= lo_out_nxt;
            upper_addr_data_port_out <= hi_out_nxt;
            lower_addr_data_port_oe <= lo_oe_nxt;
            upper_addr_data_port_oe <= hi_oe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // array outputs
    // arrays see pins three edges late: two sync stages, one register
    logic [15:0] arr_addr_nxt;
    logic [2:0] arr_ctrl_nxt;
    logic rd_act_nxt;
    logic wr_act_nxt;
    logic fetch_nxt;

    always_comb
    begin
        arr_addr_nxt = addr_nxt;
        arr_ctrl_nxt = s_ctl;
        rd_act_nxt = rd_dec;
        wr_act_nxt = wr_dec;

        // generic input when host has no fetch enable
        fetch_nxt = !s_ctl[2];
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            array_addr <= mbi_pkg::RST_ADDR;
            array_ctrl <= mbi_pkg::RST_CTRL;
            rd_active <= 1'b0;
            wr_active <= 1'b0;
            fetch_active <= 1'b0;
        end
        else
        begin
            array_addr <= arr_addr_nxt;
            array_ctrl <= arr_ctrl_nxt;
            rd_active <= rd_act_nxt;
            wr_active <= wr_act_nxt;
            fetch_active <= fetch_nxt;
        end
    end
endmodule : mbi_port

// file: rtl/mbi_pkg.sv
// package: bus modes, control selections and reset values for the port
package mbi_pkg;
    localparam int ADDR_W = 16;
    localparam int BYTE_W = 8;
    // bus wiring modes
    typedef enum logic [1:0] {
        MBI_MUX_LOW = 2'h0,
        MBI_NONMUX = 2'h1,
        MBI_PAGE = 2'h2,
        MBI_BURST = 2'h3
    } mbi_bus_mode_t;
    // control input zero meaning
    typedef enum logic {
        MBI_C0_WR_N = 1'h0,
        MBI_C0_RW = 1'h1
    } mbi_c0_mode_t;
    // control input one meaning
    typedef enum logic [1:0] {
        MBI_C1_RD_N = 2'h0,
        MBI_C1_ECLK = 2'h1,
        MBI_C1_DS_N = 2'h2,
        MBI_C1_PROGRAM_FETCH_N_N = 2'h3
    } mbi_c1_mode_t;
    // address capture state
    typedef enum logic [1:0] {
        MBI_ST_IDLE = 2'b01,
        MBI_ST_HELD = 2'b10
    } mbi_state_t;
    localparam logic [15:0] RST_ADDR = 16'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_CTRL = 3'h0;
endpackage : mbi_pkg

// file: dv/mbi_host.sv
// host model: bus pin levels seen by the port
`timescale 1ns/1ps
module mbi_host (
    input wire logic [7:0] dev_out,
    input wire logic dev_oe,
    input wire logic h_en,
    input wire logic [7:0] h_val,
    output logic [7:0] pin
);
    // released bus shows the inverse, never a stale value
    assign pin = dev_oe ? dev_out : h_en ? h_val : ~h_val;
endmodule : mbi_host

// file: dv/mbi_port_props.sv
// checker: drive, routing and hold properties of the port
`timescale 1ns/1ps
module mbi_port_props (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire mbi_pkg::mbi_bus_mode_t bus_mode,
    input wire logic addr_strobe_alt,
    input wire logic lower_addr_data_port_oe,
    input wire logic upper_addr_data_port_oe,
    input wire logic ctrl_input_zero,
    input wire logic ctrl_input_one,
    input wire logic ctrl_input_two,
    input wire logic block_select,
    input wire logic [15:0] array_addr,
    input wire logic [2:0] array_ctrl,
    input wire logic fetch_active
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire lo = lower_addr_data_port_oe;
    wire up = upper_addr_data_port_oe;
    property p_ctl; $past(rst_n, 3) && $past(rst_n, 2) && $past(rst_n) |->
        array_ctrl == $past({ctrl_input_two, ctrl_input_one,
        ctrl_input_zero}, 3); endproperty
    a_ctl: assert property (p_ctl) else $error("ctrl route");
    property p_fch; $past(rst_n, 3) && $past(rst_n, 2) && $past(rst_n) |->
        fetch_active == !$past(ctrl_input_two, 3); endproperty
    a_fch: assert property (p_fch) else $error("fetch");
    property p_sel; lo || up |-> $past(block_select, 3); endproperty
    a_sel: assert property (p_sel) else $error("unselected drive");
    property p_nmx; bus_mode == mbi_pkg::MBI_NONMUX |-> !lo && !up; endproperty
    a_nmx: assert property (p_nmx) else $error("nonmux drive");
    property p_mux; bus_mode == mbi_pkg::MBI_MUX_LOW |-> !up; endproperty
    a_mux: assert property (p_mux) else $error("upper drive");
    property p_pg; bus_mode == mbi_pkg::MBI_PAGE |-> !lo; endproperty
    a_pg: assert property (p_pg) else $error("lower drive");
    property p_hld; !addr_strobe_alt [*5] ##0 (bus_mode ==
        mbi_pkg::MBI_MUX_LOW || bus_mode == mbi_pkg::MBI_BURST) |=>
        $stable(array_addr[7:0]); endproperty
    a_hld: assert property (p_hld) else $error("low addr moved");
    property p_hlu; !addr_strobe_alt [*5] ##0 (bus_mode ==
        mbi_pkg::MBI_PAGE || bus_mode == mbi_pkg::MBI_BURST) |=>
        $stable(array_addr[15:8]); endproperty
    a_hlu: assert property (p_hlu) else $error("up addr moved");
    property p_rst; disable iff (1'b0)
        !rst_n ##1 !rst_n |-> array_addr == 16'h0000 && !lo && !up;
    endproperty
    a_rst: assert property (p_rst) else $error("reset");
endmodule : mbi_port_props
bind mbi_port mbi_port_props mbi_port_props_i (.*);

// file: dv/test_mbi_port.sv
// testbench: host bus port scenarios
`timescale 1ns/1ps
module test_mbi_port;
logic clk = 0, rst_n = 0, stb = 0, c0 = 1, c1 = 1, c2 = 1, sel = 0, hen = 1;
mbi_pkg::mbi_bus_mode_t bm = mbi_pkg::MBI_MUX_LOW;
mbi_pkg::mbi_c1_mode_t m1 = mbi_pkg::MBI_C1_RD_N;
mbi_pkg::mbi_c0_mode_t m0 = mbi_pkg::MBI_C0_WR_N;
logic [7:0] hlo = 8'h00, hup = 8'h00, lo_p, up_p, lo_o, up_o;
logic [15:0] aa;
logic [2:0] ac;
logic lo_oe, up_oe, rda, wra, fa;
int n_mismatch = 0, num_checks = 0;
mbi_port mbi_port_i (.core_clk(clk), .rst_n(rst_n), .bus_mode(bm),
    .c0_mode(m0), .c1_mode(m1), .addr_strobe_alt(stb),
    .lower_addr_data_port_in(lo_p), .lower_addr_data_port_out(lo_o),
    .lower_addr_data_port_oe(lo_oe), .upper_addr_data_port_in(up_p),
    .upper_addr_data_port_out(up_o), .upper_addr_data_port_oe(up_oe),
    .ctrl_input_zero(c0), .ctrl_input_one(c1), .ctrl_input_two(c2),
    .block_select(sel), .rd_data(16'hBEEF), .array_addr(aa),
    .array_ctrl(ac), .rd_active(rda), .wr_active(wra), .fetch_active(fa));
mbi_host mbi_host_lo (.dev_out(lo_o), .dev_oe(lo_oe), .h_en(hen),
    .h_val(hlo), .pin(lo_p));
mbi_host mbi_host_up (.dev_out(up_o), .dev_oe(up_oe), .h_en(hen),
    .h_val(hup), .pin(up_p));
initial forever #20 clk = ~clk;
task tick(input int n);
    repeat (n) @(negedge clk);
endtask : tick
task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
        n_mismatch++;
        $display("wrong value %s expected %h seen %h", nm, e, g);
    end
endtask : chk
task t_addr;
    {hup, hlo, stb} = {16'hC35A, 1'b1};
    tick(5);
    chk("addr", 16'hC35A, aa);
    stb = 0;
    tick(1);
    hlo = 8'h11;
    tick(6);
    chk("held", 16'hC35A, aa);
    $display("test addr done");
endtask : t_addr
task t_read;
    // oe {lower, upper} per mode: mux, nonmux, page, burst
    logic [1:0] e [4] = '{2'b10, 2'b00, 2'b01, 2'b11};
    for (int m = 0; m < 4; m++)
    begin
        bm = mbi_pkg::mbi_bus_mode_t'(m);
        {sel, hen, c1} = 3'h4;
        tick(5);
        chk("oe", 16'(e[m]), {lo_oe, up_oe});
        chk("rd", 16'h0001, 16'(rda));
        if (e[m][1]) chk("lo", 16'h00EF, 16'(lo_p));
        if (e[m][0]) chk("up", m == 3 ? 16'hBE : 16'hEF, 16'(up_p));
        {sel, c1} = 2'h0;
        tick(5);
        chk("nosel", 16'h0000, {lo_oe, up_oe});
        {hen, c1} = 2'h3;
        tick(5);
        chk("idle", 16'h0000, 16'({rda, lo_oe, up_oe}));
    end
    bm = mbi_pkg::MBI_MUX_LOW;
    $display("test read done");
endtask : t_read
task t_ctrl;
    for (int v = 0; v < 8; v++)
    begin
        {c2, c1, c0} = 3'(v);
        m1 = mbi_pkg::mbi_c1_mode_t'(v % 4);
        tick(4);
        chk("ctl", 16'(v), 16'(ac));
        chk("fetch", 16'(v < 4), 16'(fa));
        chk("wr", 16'(~v & 1), 16'(wra));
    end
    // direction wiring with a phase clock: phase high, c0 high reads
    m0 = mbi_pkg::MBI_C0_RW;
    m1 = mbi_pkg::MBI_C1_ECLK;
    for (int v = 0; v < 4; v++)
    begin
        {c2, c1, c0} = 3'(4 + v);
        tick(4);
        chk("rw wr", 16'(v == 2), 16'(wra));
        chk("rw rd", 16'(v == 3), 16'(rda));
    end
    m0 = mbi_pkg::MBI_C0_WR_N;
    {c2, c1, c0} = 3'h7;
    m1 = mbi_pkg::MBI_C1_RD_N;
    $display("test ctrl done");
endtask : t_ctrl
task t_rst;
    rst_n = 0;
    tick(2);
    chk("rst", 16'h0000, aa | 16'({lo_oe, up_oe}));
    rst_n = 1;
    tick(12);
    $display("test reset done");
endtask : t_rst
task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask : print_verdict
initial
begin
    tick(12);
    rst_n = 1; // low through power up
    tick(4);
    t_addr;
    t_read;
    t_ctrl;
    t_rst;
    t_addr;
    print_verdict;
end
initial
begin
    #100000;
    n_mismatch++;
    print_verdict;
end
endmodule : test_mbi_port
